// *** logic/tro_ctl.sv ***
// apb register bank and cadence sequencers for two tone oscillators and the ringing oscillator
//
// Function
// - pending-access status bit 0 reads 1 while an indirect access waits; bits above zero.
// - tone 1 control bit 7 shows whether tone 1 output is active.
// - tone 1 auto-restart clear stops after off period; set keeps reloading and running.
// - tone 1 zero-cross bit delays signal end to first zero crossing after on expiry.
// - tone 1 bits 4 and 3 enable its on-period and off-period timers.
// - control bit 2 switches each tone oscillator on or off.
// - routing 00 none, 01 transmit, 10 receive, 11 both paths.
// - tone 2 control bit 7 shows whether tone 2 output is active.
// - tone 2 zero-cross bit makes its signal end at a zero crossing.
// - tone 2 bits 4 and 3 enable its on-period and off-period timers.
// - ring control bit 7 shows whether ringing oscillator output is active.
// - ring drive waits for joining the dc feed; bit 5 shows ringing on line.
// - ring bits 4 and 3 enable ringing on-period and off-period timers.
// - ring control bit 2 is a read-only copy of ringing oscillator enable.
// - ring control bit 1 adds a dc offset to the ringing waveform.
// - ring control bit 0 selects sinusoid (0) or trapezoid (1).
// - cadence timer values count in 125 us steps.
// - address write alone reads, data then address writes; done at next 16 kHz update.
`timescale 1ns/1ps

module tro_ctl
  import tro_pkg::*;
#(
  parameter int unsigned P_CADENCE_LSB_CYC = CADENCE_LSB_CYC
) (
  input  wire logic         I_MCLK,
  input  wire logic         I_RST_N,
  input  wire logic         I_PSEL,
  input  wire logic         I_PENABLE,
  input  wire logic         I_PWRITE,
  input  wire logic [11:0]  I_PADDR,
  input  wire logic [31:0]  I_PWDATA,
  output logic [31:0]       O_PRDATA,
  output logic              O_PREADY,
  output logic              O_PSLVERR,
  input  wire logic [1:0]   I_TONE_ZERO_CROSS,
  input  wire logic         I_RING_FEED_CROSS,
  input  wire logic [15:0]  I_IND_RDATA,
  output logic [1:0]        O_TONE_TX,
  output logic [1:0]        O_TONE_RX,
  output logic              O_RING_DRIVE,
  output logic              O_RING_DC_OFFSET,
  output logic              O_RING_TRAPEZOID,
  output tro_ind_req_s      O_IND_REQ
);

  if (P_CADENCE_LSB_CYC < 1 || P_CADENCE_LSB_CYC > (1 << SUB_W)) begin : g_bad_lsb
    $error("cadence step count out of range for the step counter");
  end

  localparam logic [SUB_W-1:0] LSB_LAST = SUB_W'(P_CADENCE_LSB_CYC - 1);
  localparam logic [UPD_W-1:0] UPD_LAST = UPD_W'(IND_UPDATE_CYC - 1);

  tro_state_s s_reg;
  tro_state_s s_next;

  // read decode: bit 8 flags a mapped index
  function automatic logic [8:0] read_reg(input tro_state_s s, input logic [7:0] idx);
    logic [8:0] r;
    r = 9'h000;
    unique case (idx)
      IDX_IND_DATA_LO: r = {1'h1, s.ind_data[7:0]};
      IDX_IND_DATA_HI: r = {1'h1, s.ind_data[15:8]};
      IDX_IND_ADDR:    r = {1'h1, s.ind_addr};
      IDX_IND_PENDING: r = {1'h1, 7'h00, s.pending};
      IDX_TONE1_CTL:   r = {1'h1, s.active[0], s.ctl[0][6:0]};
      IDX_TONE2_CTL:   r = {1'h1, s.active[1], 1'h0, s.ctl[1][5:0]};
      IDX_RING_CTL:    r = {1'h1, s.active[2], 1'h0, s.ring_line, s.ctl[2][4:3],
                            s.ring_en, s.ctl[2][1:0]};
      IDX_RING_ENABLE: r = {1'h1, 7'h00, s.ring_en};
      default:         r = 9'h000;
    endcase
    for (int i = 0; i < NOSC; i++) begin
      if (idx[7:2] == TMR_BASE[i][7:2]) begin
        r = {1'h1, idx[0] ? s.tmr[i][idx[1]][15:8] : s.tmr[i][idx[1]][7:0]};
      end
    end
    return r;
  endfunction

  logic [7:0] idx;
  logic       aligned;
  logic [8:0] rd;
  logic       wr_take;
  logic [7:0] wbyte;

  assign idx     = I_PADDR[9:2];
  assign aligned = (I_PADDR[1:0] == 2'h0) && (I_PADDR[11:10] == 2'h0);
  assign rd      = read_reg(s_reg, idx);
  // a write lands only at the access edge that completes the transfer
  assign wr_take = I_PSEL && I_PENABLE && s_reg.pready && I_PWRITE && !s_reg.pslverr;
  assign wbyte   = I_PWDATA[7:0];

  always_comb begin
    logic             en;
    logic             zc_stop;
    logic             restart;
    logic [2:0]       zc_in;
    logic             step;
    logic             expired;
    logic             counting;
    logic             load_on;
    logic             load_off;
    en       = 1'h0;
    zc_stop  = 1'h0;
    restart  = 1'h0;
    zc_in    = {1'h0, I_TONE_ZERO_CROSS};
    step     = 1'h0;
    expired  = 1'h0;
    counting = 1'h0;
    load_on  = 1'h0;
    load_off = 1'h0;
    s_next   = s_reg;

    // apb: setup cycle prepares the answer, access cycle completes with no wait state
    s_next.pready  = 1'h0;
    s_next.pslverr = 1'h0;
    if (I_PSEL && !I_PENABLE) begin
      s_next.pready  = 1'h1;
      s_next.pslverr = !(rd[8] && aligned);
      s_next.prdata  = (rd[8] && aligned && !I_PWRITE) ? {24'h000000, rd[7:0]} : 32'h00000000;
    end

    // indirect update runs at the 16 kHz rate
    s_next.req.strobe = 1'h0;
    s_next.upd = (s_reg.upd == UPD_LAST) ? '0 : UPD_W'(s_reg.upd + 1'h1);
    if (s_reg.upd == UPD_LAST && s_reg.pending) begin
      s_next.req.strobe = 1'h1;
      s_next.req.write  = s_reg.wr_op;
      s_next.req.addr   = s_reg.ind_addr;
      s_next.req.wdata  = s_reg.ind_data;
      if (!s_reg.wr_op) begin
        s_next.ind_data = I_IND_RDATA;
      end
      s_next.pending = 1'h0;
    end

    // cadence sequencers
    for (int i = 0; i < NOSC; i++) begin
      en       = (i == 2) ? s_reg.ring_en : s_reg.ctl[i][BIT_ENABLE];
      zc_stop  = (i != 2) && s_reg.ctl[i][BIT_ZC_STOP];
      // only tone 1 may stop after a timed off period; the others restart there
      restart  = (i == 0) ? s_reg.ctl[0][BIT_RESTART] : 1'h1;
      counting = (s_reg.st[i] == CAD_ON  && s_reg.ctl[i][BIT_ON_TEN]) ||
                 (s_reg.st[i] == CAD_OFF && s_reg.ctl[i][BIT_OFF_TEN]);
      step     = counting && (s_reg.sub[i] == LSB_LAST);
      expired  = step && (s_reg.unit[i] <= UNIT_W'(1));
      load_on  = 1'h0;
      load_off = 1'h0;
      if (counting) begin
        s_next.sub[i] = step ? '0 : SUB_W'(s_reg.sub[i] + 1'h1);
        if (step && !expired) begin
          s_next.unit[i] = UNIT_W'(s_reg.unit[i] - 1'h1);
        end
      end
      unique case (s_reg.st[i])
        CAD_IDLE: begin
          load_on = en;
        end
        CAD_ON: begin
          if (expired) begin
            if (zc_stop) begin
              s_next.st[i] = CAD_ZWAIT;
            end else begin
              load_off = 1'h1;
            end
          end
        end
        CAD_ZWAIT: begin
          load_off = zc_in[i];
        end
        CAD_OFF: begin
          if (!s_reg.ctl[i][BIT_OFF_TEN]) begin
            s_next.st[i] = CAD_DONE;
          end else if (expired) begin
            if (restart) begin
              load_on = 1'h1;
            end else begin
              s_next.st[i] = CAD_DONE;
            end
          end
        end
        CAD_DONE: begin
          s_next.st[i] = CAD_DONE;
        end
      endcase
      // entering a period rereads the programmed length
      if (load_on) begin
        s_next.st[i]   = CAD_ON;
        s_next.unit[i] = s_reg.tmr[i][0];
        s_next.sub[i]  = '0;
      end
      if (load_off) begin
        s_next.st[i]   = CAD_OFF;
        s_next.unit[i] = s_reg.tmr[i][1];
        s_next.sub[i]  = '0;
      end
      if (!en) begin
        s_next.st[i] = CAD_IDLE;
      end
      s_next.active[i] = (s_next.st[i] == CAD_ON) || (s_next.st[i] == CAD_ZWAIT);
    end

    for (int i = 0; i < 2; i++) begin
      s_next.tone_tx[i] = s_next.active[i] && s_reg.ctl[i][BIT_ROUTE_TX];
      s_next.tone_rx[i] = s_next.active[i] && s_reg.ctl[i][BIT_ROUTE_RX];
    end

    // line drive changes only where the waveform meets the dc feed level
    if (s_reg.active[2] && !s_reg.ring_line && I_RING_FEED_CROSS) begin
      s_next.ring_line = 1'h1;
    end else if (!s_reg.active[2] && s_reg.ring_line && I_RING_FEED_CROSS) begin
      s_next.ring_line = 1'h0;
    end

    // register writes come last so a new address write wins over a completing update
    if (wr_take) begin
      unique case (idx)
        IDX_IND_DATA_LO: begin
          s_next.ind_data[7:0] = wbyte;
          s_next.data_wr       = 1'h1;
        end
        IDX_IND_DATA_HI: begin
          s_next.ind_data[15:8] = wbyte;
          s_next.data_wr        = 1'h1;
        end
        IDX_IND_ADDR: begin
          s_next.ind_addr = wbyte;
          s_next.pending  = 1'h1;
          s_next.wr_op    = s_reg.data_wr;
          s_next.data_wr  = 1'h0;
        end
        IDX_TONE1_CTL:   s_next.ctl[0] = wbyte & CTL_WMASK[0];
        IDX_TONE2_CTL:   s_next.ctl[1] = wbyte & CTL_WMASK[1];
        IDX_RING_CTL:    s_next.ctl[2] = wbyte & CTL_WMASK[2];
        IDX_RING_ENABLE: s_next.ring_en = wbyte[0];
        default: begin
          for (int i = 0; i < NOSC; i++) begin
            if (idx[7:2] == TMR_BASE[i][7:2]) begin
              if (idx[0]) begin
                s_next.tmr[i][idx[1]][15:8] = wbyte;
              end else begin
                s_next.tmr[i][idx[1]][7:0] = wbyte;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s_reg         <= '0;
      s_reg.ctl     <= {NOSC{CTL_RST}};
      s_reg.tmr     <= {(2 * NOSC){TMR_RST}};
      s_reg.st      <= '{default: CAD_IDLE};
    end else begin
      s_reg <= s_next;
    end
  end

  assign O_PRDATA         = s_reg.prdata;
  assign O_PREADY         = s_reg.pready;
  assign O_PSLVERR        = s_reg.pslverr;
  assign O_TONE_TX        = s_reg.tone_tx;
  assign O_TONE_RX        = s_reg.tone_rx;
  assign O_RING_DRIVE     = s_reg.ring_line;
  assign O_RING_DC_OFFSET = s_reg.ctl[2][BIT_DC_OFS];
  assign O_RING_TRAPEZOID = s_reg.ctl[2][BIT_TRAPEZ];
  assign O_IND_REQ        = s_reg.req;

endmodule

// *** logic/tro_pkg.sv ***
// constants, types and register map of the tone and ringing oscillator control bank
package tro_pkg;

  // clock and time bases
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned CADENCE_LSB_NS  = 125000;
  localparam int unsigned CADENCE_LSB_CYC = CADENCE_LSB_NS / CLK_PERIOD_NS;
  localparam int unsigned IND_UPDATE_NS   = 62500;
  localparam int unsigned IND_UPDATE_CYC  = IND_UPDATE_NS / CLK_PERIOD_NS;

  // counter widths and oscillator count
  localparam int unsigned SUB_W  = 16;
  localparam int unsigned UNIT_W = 16;
  localparam int unsigned UPD_W  = 12;
  localparam int unsigned NOSC   = 3;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_IND_DATA_LO  = 8'h1C;
  localparam logic [7:0] IDX_IND_DATA_HI  = 8'h1D;
  localparam logic [7:0] IDX_IND_ADDR     = 8'h1E;
  localparam logic [7:0] IDX_IND_PENDING  = 8'h1F;
  localparam logic [7:0] IDX_TONE1_CTL    = 8'h20;
  localparam logic [7:0] IDX_TONE2_CTL    = 8'h21;
  localparam logic [7:0] IDX_RING_CTL     = 8'h22;
  localparam logic [7:0] IDX_RING_ENABLE  = 8'h23;
  // per oscillator: on low, on high, off low, off high
  localparam logic [NOSC-1:0][7:0] TMR_BASE = {8'h30, 8'h28, 8'h24};

  // control field positions
  localparam int unsigned BIT_STATUS   = 7;
  localparam int unsigned BIT_RESTART  = 6;
  localparam int unsigned BIT_ZC_STOP  = 5;
  localparam int unsigned BIT_ON_LINE  = 5;
  localparam int unsigned BIT_ON_TEN   = 4;
  localparam int unsigned BIT_OFF_TEN  = 3;
  localparam int unsigned BIT_ENABLE   = 2;
  localparam int unsigned BIT_ROUTE_TX = 0;
  localparam int unsigned BIT_ROUTE_RX = 1;
  localparam int unsigned BIT_DC_OFS   = 1;
  localparam int unsigned BIT_TRAPEZ   = 0;

  // writable bits per control register, and reset values
  localparam logic [NOSC-1:0][7:0] CTL_WMASK = {8'h1B, 8'h3F, 8'h7F};
  localparam logic [7:0]           CTL_RST   = 8'h00;
  localparam logic [15:0]          TMR_RST   = 16'h0000;

  typedef enum logic [2:0] {CAD_IDLE, CAD_ON, CAD_ZWAIT, CAD_OFF, CAD_DONE} tro_cad_e;

  typedef struct packed {
    logic        strobe;
    logic        write;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } tro_ind_req_s;

  typedef struct packed {
    logic [31:0]                       prdata;
    logic                              pready;
    logic                              pslverr;
    logic [NOSC-1:0][7:0]              ctl;
    logic                              ring_en;
    logic [NOSC-1:0][1:0][15:0]        tmr;
    tro_cad_e [NOSC-1:0]               st;
    logic [NOSC-1:0][UNIT_W-1:0]       unit;
    logic [NOSC-1:0][SUB_W-1:0]        sub;
    logic [NOSC-1:0]                   active;
    logic                              ring_line;
    logic [1:0]                        tone_tx;
    logic [1:0]                        tone_rx;
    logic [UPD_W-1:0]                  upd;
    logic                              pending;
    logic                              data_wr;
    logic                              wr_op;
    logic [7:0]                        ind_addr;
    logic [15:0]                       ind_data;
    tro_ind_req_s                      req;
  } tro_state_s;

endpackage

// *** sim/tro_ctl_chk.sv ***
// assertion checker for the oscillator control register bank
`timescale 1ns/1ps
module tro_ctl_chk
  import tro_pkg::*;
#(
  parameter int unsigned P_CADENCE_LSB_CYC = CADENCE_LSB_CYC
) (
  input wire logic         I_MCLK,
  input wire logic         I_RST_N,
  input wire logic         I_PSEL,
  input wire logic         I_PENABLE,
  input wire logic         I_PWRITE,
  input wire logic [11:0]  I_PADDR,
  input wire logic [31:0]  I_PWDATA,
  input wire logic [31:0]  O_PRDATA,
  input wire logic         O_PREADY,
  input wire logic         O_PSLVERR,
  input wire logic [1:0]   I_TONE_ZERO_CROSS,
  input wire logic         I_RING_FEED_CROSS,
  input wire logic [15:0]  I_IND_RDATA,
  input wire logic [1:0]   O_TONE_TX,
  input wire logic [1:0]   O_TONE_RX,
  input wire logic         O_RING_DRIVE,
  input wire logic         O_RING_DC_OFFSET,
  input wire logic         O_RING_TRAPEZOID,
  input wire tro_ind_req_s O_IND_REQ
);
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_N);
  sequence s_setup_rd;
    I_PSEL && !I_PENABLE && !I_PWRITE;
  endsequence
  sequence s_setup_wr;
    I_PSEL && !I_PENABLE && I_PWRITE;
  endsequence
  chk_ready_after_setup: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("ready missing after setup");
  chk_ready_one_cycle: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready held too long");
  chk_err_with_ready: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error without ready");
  chk_err_unmapped: assert property (I_PSEL && !I_PENABLE && I_PADDR[9:2] > 8'h33
    |=> O_PSLVERR && O_PRDATA == 32'h0) else $error("unmapped access not refused");
  chk_write_rdata_zero: assert property (s_setup_wr |=> O_PRDATA == 32'h0)
    else $error("read data on a write");
  chk_status_upper_zero: assert property (s_setup_rd ##0 I_PADDR == 12'h07C
    |=> O_PRDATA[31:1] == 31'h0) else $error("status upper bits set");
  chk_tone2_bit6_zero: assert property (s_setup_rd ##0 I_PADDR == 12'h084
    |=> !O_PRDATA[6]) else $error("tone two reserved bit set");
  chk_ring_shape_out: assert property (s_setup_rd ##0 I_PADDR == 12'h088
    |=> O_PRDATA[1:0] == {O_RING_DC_OFFSET, O_RING_TRAPEZOID} && !O_PRDATA[6])
    else $error("ring shape outputs disagree with control");
  chk_strobe_spacing: assert property (O_IND_REQ.strobe |=> !O_IND_REQ.strobe [*8])
    else $error("indirect strobe too close");
  chk_drive_on_cross: assert property ($rose(O_RING_DRIVE) |->
    $past(I_RING_FEED_CROSS) || $past(I_RING_FEED_CROSS, 2) || $past(I_RING_FEED_CROSS, 3))
    else $error("ring drive rose off the feed crossing");
endmodule

bind tro_ctl tro_ctl_chk #(.P_CADENCE_LSB_CYC(P_CADENCE_LSB_CYC)) u_chk (.*);

// *** sim/tro_ctl_test.sv ***
// self-checking bench for the oscillator control register bank
`timescale 1ns/1ps
module tro_ctl_test
  import tro_pkg::*;
;
  logic         clk, rst_n, psel, penable, pwrite, pready, pslverr, rdy, err;
  logic         ring_feed, ring_drive, ring_dc, ring_trap;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [1:0]   zero_cross, tone_tx, tone_rx;
  logic [15:0]  ind_rdata;
  tro_ind_req_s ind_req;
  int           mismatches, total_checks, cnt;

  // short cadence unit keeps each 125 us step at four clocks
  tro_ctl #(.P_CADENCE_LSB_CYC(4)) dut (
    .I_MCLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_TONE_ZERO_CROSS(zero_cross),
    .I_RING_FEED_CROSS(ring_feed), .I_IND_RDATA(ind_rdata), .O_TONE_TX(tone_tx),
    .O_TONE_RX(tone_rx), .O_RING_DRIVE(ring_drive), .O_RING_DC_OFFSET(ring_dc),
    .O_RING_TRAPEZOID(ring_trap), .O_IND_REQ(ind_req)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic stop_test();
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // the request stands until the rising edge at which ready is seen high; data taken there
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      rdy = pready;
      rd = prdata;
      err = pslverr;
      n++;
    end while (rdy !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n, 32'd1, "access cycles");
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp, "read data");
  endtask

  task automatic count_on(input int n);
    cnt = 0;
    repeat (n) begin
      @(negedge clk);
      cnt += int'(tone_tx[0] === 1'b1);
    end
  endtask

  task automatic wait_strobe();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ind_req.strobe !== 1'b1 && n < 3000);
    chk({31'h0, ind_req.strobe}, 32'h1, "indirect strobe");
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  initial begin
    {rst_n, psel, penable, pwrite, ring_feed} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    zero_cross = 2'h0;
    ind_rdata = 16'hA5C3;
    mismatches = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rdc(8'h1F, 32'h0);
    rdc(8'h20, 32'h0);
    rdc(8'h21, 32'h0);
    rdc(8'h22, 32'h0);
    apb(1'b0, 8'h40, 8'h00);
    chk({31'h0, err}, 32'h1, "unmapped error");
    apb(1'b1, 8'h1F, 8'hFF);
    rdc(8'h1F, 32'h0);
    apb(1'b1, 8'h20, 8'hFB);
    rdc(8'h20, 32'h7B);
    apb(1'b1, 8'h21, 8'hFB);
    rdc(8'h21, 32'h3B);
    apb(1'b1, 8'h22, 8'hFF);
    rdc(8'h22, 32'h1B);
    chk({30'h0, ring_dc, ring_trap}, 32'h3, "ring shape");
    apb(1'b1, 8'h22, 8'h00);
    rdc(8'h22, 32'h0);
    chk({30'h0, ring_dc, ring_trap}, 32'h0, "ring shape");
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, 8'h20, {6'h01, r[1:0]});
      apb(1'b1, 8'h21, {6'h01, ~r[1:0]});
      rdc(8'h20, {24'h0, 6'h21, r[1:0]});
      rdc(8'h21, {24'h0, 6'h21, ~r[1:0]});
      chk({28'h0, tone_rx, tone_tx}, {28'h0, ~r[1], r[1], ~r[0], r[0]}, "route");
    end
    apb(1'b1, 8'h20, 8'h00);
    apb(1'b1, 8'h21, 8'h00);
    rdc(8'h20, 32'h0);
    chk({28'h0, tone_rx, tone_tx}, 32'h0, "route off");
    apb(1'b1, 8'h24, 8'h02);
    apb(1'b1, 8'h26, 8'h03);
    apb(1'b1, 8'h20, 8'h1D);
    count_on(90);
    chk(cnt, 32'd8, "single burst");
    apb(1'b1, 8'h20, 8'h00);
    apb(1'b1, 8'h20, 8'h5D);
    count_on(90);
    chk(cnt, 32'd40, "cadence");
    apb(1'b1, 8'h20, 8'h00);
    apb(1'b1, 8'h20, 8'h35);
    repeat (30) @(negedge clk);
    chk({31'h0, tone_tx[0]}, 32'h1, "held for crossing");
    @(posedge clk);
    zero_cross <= 2'h1;
    repeat (4) @(negedge clk);
    chk({31'h0, tone_tx[0]}, 32'h0, "ended at crossing");
    @(posedge clk);
    zero_cross <= 2'h0;
    apb(1'b1, 8'h20, 8'h00);
    apb(1'b1, 8'h28, 8'h01);
    apb(1'b1, 8'h21, 8'h36);
    repeat (30) @(negedge clk);
    chk({31'h0, tone_rx[1]}, 32'h1, "tone two held for crossing");
    @(posedge clk);
    zero_cross <= 2'h2;
    repeat (4) @(negedge clk);
    chk({31'h0, tone_rx[1]}, 32'h0, "tone two ended at crossing");
    @(posedge clk);
    zero_cross <= 2'h0;
    apb(1'b1, 8'h21, 8'h00);
    apb(1'b1, 8'h23, 8'h01);
    rdc(8'h22, 32'h84);
    ring_feed <= 1'b1;
    repeat (4) @(negedge clk);
    chk({31'h0, ring_drive}, 32'h1, "ring on line");
    rdc(8'h22, 32'hA4);
    apb(1'b1, 8'h23, 8'h00);
    repeat (4) @(negedge clk);
    chk({31'h0, ring_drive}, 32'h0, "ring off line");
    @(posedge clk);
    ring_feed <= 1'b0;
    apb(1'b1, 8'h1E, 8'h55);
    rdc(8'h1F, 32'h1);
    wait_strobe();
    chk({23'h0, ind_req.write, ind_req.addr}, 32'h55, "indirect read");
    rdc(8'h1F, 32'h0);
    rdc(8'h1C, 32'hC3);
    rdc(8'h1D, 32'hA5);
    apb(1'b1, 8'h1C, 8'h12);
    apb(1'b1, 8'h1D, 8'h34);
    apb(1'b1, 8'h1E, 8'h66);
    wait_strobe();
    chk({7'h0, ind_req.write, ind_req.addr, ind_req.wdata}, 32'h01663412, "ind write");
    stop_test();
  end
endmodule
